// ===== logic/itdte_engine.sv
// interrupt-triggered transfer engine: catches level-7 peripheral requests,
// walks the parameter index in RAM and moves, fills or adds 8/16-bit units.
// assumes an APB master, a byte-wide RAM port and same-clock request sources.
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
`include "itdte_defines.svh"
module itdte_engine
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] periph_req,
  input wire logic [23:0] request_priority_level,
  output logic [7:0] cpu_irq_req,
  output itdte_pkg::itdte_mem_t mem,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata,
  output logic done_irq,
  output logic [31:0] done_handler,
  output logic [2:0] done_source
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  itdte_pkg::itdte_state_t state;
  itdte_pkg::itdte_acc_t acc;
  logic transfer_function_select;
  logic [23:0] vbase;
  logic [15:0] dones;
  logic [7:0] trig_mask;
  logic [7:0] pending;
  logic [2:0] src_id;
  logic issued;
  logic seq_start;
  logic seq_done;
  logic [31:0] seq_rdata;
  logic [23:0] idx_base;
  logic [23:0] fld_ptr;
  logic [23:0] opa_loc;
  logic [23:0] dst_loc;
  logic [15:0] mode_word;
  logic [15:0] count;
  logic [15:0] source_field;
  logic [15:0] operand_address_field;
  logic [15:0] destination_field;
  logic [31:0] chain_address_field;
  logic [31:0] handler_address_field;
  logic [15:0] src_data;
  logic [2:0] pairs_left;
  logic [1:0] wb_step;
  logic unit16;
  logic srcmem;
  logic oper;
  logic burst_select;
  logic multi_pair_enable;
  logic [2:0] pair_quantity;
  logic [2:0] unit_len;
  logic [15:0] step;
  logic [15:0] sum;
  logic burst_busy;
  logic apb_setup;
  logic apb_access;

  function automatic logic [15:0] unit_trunc(input logic [15:0] v, input logic wide);
    unit_trunc = wide ? v : {8'h00, v[7:0]};
  endfunction

  function automatic logic [2:0] lowest(input logic [7:0] v);
    integer i;
    lowest = 3'h0;
    for (i = 7; i >= 0; i = i - 1)
      if (v[i])
        lowest = 3'(i);
  endfunction

  assign unit16 = mode_word[`ITDTE_MOD_UNIT16];
  assign srcmem = mode_word[`ITDTE_MOD_SRCMEM];
  assign oper = mode_word[`ITDTE_MOD_OPER];
  assign burst_select = mode_word[`ITDTE_MOD_BURST_SELECT];
  assign multi_pair_enable = mode_word[`ITDTE_MOD_MULTI_PAIR_ENABLE];
  assign pair_quantity = mode_word[`ITDTE_MOD_CNT_HI:`ITDTE_MOD_CNT_LO];
  assign unit_len = unit16 ? 3'h2 : 3'h1;
  assign step = unit16 ? 16'h0002 : 16'h0001;
  assign sum = unit_trunc(src_data + unit_trunc(seq_rdata[15:0], unit16), unit16);
  assign burst_busy = (state != itdte_pkg::S_IDLE) && burst_select && !multi_pair_enable;

  // ----------------------------------------
  // trigger capture and forwarding
  // ----------------------------------------
  // no CPU flag or processor level is consulted here on purpose
  always_comb
  begin
    for (int i = 0; i < `ITDTE_NSRC; i++)
      trig_mask[i] = transfer_function_select &&
        (request_priority_level[i*3 +: 3] == `ITDTE_LVL_TRIG);
  end

  // a new request in the cycle its bit is taken stays pending
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pending <= 8'h00;
    else if (state == itdte_pkg::S_IDLE && pending != 8'h00)
      pending <= (pending & ~(8'h01 << lowest(pending))) | (periph_req & trig_mask);
    else
      pending <= pending | (periph_req & trig_mask);
  end

  // while a burst runs nothing reaches the CPU
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cpu_irq_req <= 8'h00;
    else if (burst_busy)
      cpu_irq_req <= 8'h00;
    else
      cpu_irq_req <= periph_req & ~trig_mask;
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  assign apb_setup = psel && !penable;
  assign apb_access = psel && penable;
  assign pready = 1'b1;
  assign pslverr = apb_access && !(paddr == `ITDTE_OFS_CTRL || paddr == `ITDTE_OFS_VBASE ||
    paddr == `ITDTE_OFS_STATUS || paddr == `ITDTE_OFS_DONES);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      transfer_function_select <= `ITDTE_CTRL_RST;
      vbase <= `ITDTE_VBASE_RST;
    end
    else if (apb_access && pwrite)
    begin
      if (paddr == `ITDTE_OFS_CTRL)
        transfer_function_select <= pwdata[`ITDTE_CTRL_FSEL];
      else if (paddr == `ITDTE_OFS_VBASE)
        vbase <= pwdata[23:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (apb_setup && !pwrite)
    begin
      if (paddr == `ITDTE_OFS_CTRL)
        prdata <= {31'h0000_0000, transfer_function_select};
      else if (paddr == `ITDTE_OFS_VBASE)
        prdata <= {8'h00, vbase};
      else if (paddr == `ITDTE_OFS_STATUS)
        prdata <= {16'h0000, pending, 1'b0, src_id, state};
      else if (paddr == `ITDTE_OFS_DONES)
        prdata <= {16'h0000, dones};
      else
        prdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // byte sequencer
  // ----------------------------------------
  assign seq_start = !issued && (state != itdte_pkg::S_IDLE) && (state != itdte_pkg::S_FIN) &&
    !(state == itdte_pkg::S_RDS && !srcmem && !multi_pair_enable) &&
    !(state == itdte_pkg::S_RDO && !oper);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      issued <= 1'b0;
    else if (seq_done)
      issued <= 1'b0;
    else if (seq_start)
      issued <= 1'b1;
  end

  always_comb
  begin
    acc.write = 1'b0;
    acc.addr = fld_ptr;
    acc.len = 3'h2;
    acc.wdata = 32'h0000_0000;
    case (state)
      itdte_pkg::S_VEC: begin acc.addr = vbase + {19'h0_0000, src_id, 2'b00}; acc.len = 3'h4; end
      itdte_pkg::S_HDR: begin acc.addr = idx_base; acc.len = 3'h4; end
      itdte_pkg::S_CHN: acc.len = 3'h4;
      itdte_pkg::S_HND: acc.len = 3'h4;
      itdte_pkg::S_PAIR: acc.len = 3'h4;
      itdte_pkg::S_RDS: begin acc.addr = {`ITDTE_ADDR_TOP, source_field}; acc.len = unit_len; end
      itdte_pkg::S_RDO: begin acc.addr = {`ITDTE_ADDR_TOP, operand_address_field}; acc.len = unit_len; end
      itdte_pkg::S_WRD:
      begin
        acc.write = 1'b1;
        acc.addr = {`ITDTE_ADDR_TOP, destination_field};
        acc.len = unit_len;
        // src_data already carries the sum here: adding again would double-count
        acc.wdata = {16'h0000, unit_trunc(src_data, unit16)};
      end
      itdte_pkg::S_WBK:
      begin
        acc.write = 1'b1;
        if (wb_step == 2'h0)
        begin
          acc.addr = idx_base + `ITDTE_IDX_COUNT;
          acc.len = 3'h4;
          acc.wdata = {source_field, count};
        end
        else if (wb_step == 2'h1)
        begin
          acc.addr = opa_loc;
          acc.wdata = {16'h0000, operand_address_field};
        end
        else
        begin
          acc.addr = dst_loc;
          acc.wdata = {16'h0000, destination_field};
        end
      end
      itdte_pkg::S_CHW:
      begin
        acc.write = 1'b1;
        acc.addr = vbase + {19'h0_0000, src_id, 2'b00};
        acc.len = 3'h4;
        acc.wdata = chain_address_field;
      end
      default: acc.len = 3'h2;
    endcase
  end

  itdte_mem_seq u_seq
  (
    .pclk(pclk),
    .presetn(presetn),
    .start(seq_start),
    .acc(acc),
    .mem(mem),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata),
    .done(seq_done),
    .rdata(seq_rdata)
  );

  // ----------------------------------------
  // index walk and transfer sequence
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= itdte_pkg::S_IDLE;
      src_id <= 3'h0;
      idx_base <= 24'h00_0000;
      fld_ptr <= 24'h00_0000;
      opa_loc <= 24'h00_0000;
      dst_loc <= 24'h00_0000;
      mode_word <= 16'h0000;
      count <= 16'h0000;
      source_field <= 16'h0000;
      operand_address_field <= 16'h0000;
      destination_field <= 16'h0000;
      chain_address_field <= 32'h0000_0000;
      handler_address_field <= 32'h0000_0000;
      src_data <= 16'h0000;
      pairs_left <= 3'h0;
      wb_step <= 2'h0;
    end
    else
    begin
      case (state)
        itdte_pkg::S_IDLE:
          if (pending != 8'h00)
          begin
            src_id <= lowest(pending);
            state <= itdte_pkg::S_VEC;
          end
        itdte_pkg::S_VEC:
          if (seq_done)
          begin
            idx_base <= seq_rdata[23:0];
            state <= itdte_pkg::S_HDR;
          end
        itdte_pkg::S_HDR:
          if (seq_done)
          begin
            mode_word <= seq_rdata[15:0];
            count <= seq_rdata[31:16];
            fld_ptr <= idx_base + `ITDTE_IDX_SRC;
            pairs_left <= seq_rdata[`ITDTE_MOD_CNT_HI:`ITDTE_MOD_CNT_LO];
            state <= seq_rdata[`ITDTE_MOD_MULTI_PAIR_ENABLE] ? itdte_pkg::S_PAIR : itdte_pkg::S_SRC;
          end
        itdte_pkg::S_SRC:
          if (seq_done)
          begin
            source_field <= seq_rdata[15:0];
            fld_ptr <= fld_ptr + 24'h00_0002;
            opa_loc <= fld_ptr + 24'h00_0002;
            dst_loc <= fld_ptr + (oper ? 24'h00_0004 : 24'h00_0002);
            state <= oper ? itdte_pkg::S_OPA : itdte_pkg::S_DST;
          end
        itdte_pkg::S_OPA:
          if (seq_done)
          begin
            operand_address_field <= seq_rdata[15:0];
            fld_ptr <= fld_ptr + 24'h00_0002;
            state <= itdte_pkg::S_DST;
          end
        itdte_pkg::S_DST:
          if (seq_done)
          begin
            destination_field <= seq_rdata[15:0];
            fld_ptr <= fld_ptr + 24'h00_0002;
            if (mode_word[`ITDTE_MOD_CHAIN])
              state <= itdte_pkg::S_CHN;
            else if (mode_word[`ITDTE_MOD_INTE])
              state <= itdte_pkg::S_HND;
            else
              state <= (count == 16'h0000) ? itdte_pkg::S_FIN : itdte_pkg::S_RDS;
          end
        itdte_pkg::S_CHN:
          if (seq_done)
          begin
            chain_address_field <= seq_rdata;
            fld_ptr <= fld_ptr + 24'h00_0004;
            if (mode_word[`ITDTE_MOD_INTE])
              state <= itdte_pkg::S_HND;
            else
              state <= (count == 16'h0000) ? itdte_pkg::S_FIN : itdte_pkg::S_RDS;
          end
        itdte_pkg::S_HND:
          if (seq_done)
          begin
            handler_address_field <= seq_rdata;
            state <= (count == 16'h0000) ? itdte_pkg::S_FIN : itdte_pkg::S_RDS;
          end
        itdte_pkg::S_PAIR:
          if (seq_done)
          begin
            source_field <= seq_rdata[15:0];
            destination_field <= seq_rdata[31:16];
            fld_ptr <= fld_ptr + 24'h00_0004;
            state <= itdte_pkg::S_RDS;
          end
        itdte_pkg::S_RDS:
          if (!srcmem && !multi_pair_enable)
          begin
            src_data <= unit_trunc(source_field, unit16);
            state <= itdte_pkg::S_RDO;
          end
          else if (seq_done)
          begin
            src_data <= unit_trunc(seq_rdata[15:0], unit16);
            state <= itdte_pkg::S_RDO;
          end
        itdte_pkg::S_RDO:
          if (!oper)
            state <= itdte_pkg::S_WRD;
          else if (seq_done)
          begin
            src_data <= sum;
            state <= itdte_pkg::S_WRD;
          end
        itdte_pkg::S_WRD:
          if (seq_done)
          begin
            if (multi_pair_enable)
            begin
              pairs_left <= pairs_left - 3'h1;
              state <= (pairs_left == 3'h1) ? itdte_pkg::S_FIN : itdte_pkg::S_PAIR;
            end
            else
            begin
              count <= count - 16'h0001;
              if (mode_word[`ITDTE_MOD_UPDS] && srcmem)
                source_field <= source_field + step;
              if (mode_word[`ITDTE_MOD_UPDS] && srcmem && oper)
                operand_address_field <= operand_address_field + step;
              if (mode_word[`ITDTE_MOD_UPDD])
                destination_field <= destination_field + step;
              wb_step <= 2'h0;
              if (burst_select && count != 16'h0001)
                state <= itdte_pkg::S_RDS;
              else
                state <= itdte_pkg::S_WBK;
            end
          end
        itdte_pkg::S_WBK:
          if (seq_done)
          begin
            // keep the index current so the next request resumes from here
            if (wb_step == 2'h0)
              wb_step <= oper ? 2'h1 : 2'h2;
            else if (wb_step == 2'h1)
              wb_step <= 2'h2;
            else if (count == 16'h0000 && mode_word[`ITDTE_MOD_CHAIN])
              state <= itdte_pkg::S_CHW;
            else
              state <= itdte_pkg::S_FIN;
          end
        itdte_pkg::S_CHW:
          if (seq_done)
            state <= itdte_pkg::S_FIN;
        default:
          state <= itdte_pkg::S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // completion
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_irq <= 1'b0;
      done_handler <= 32'h0000_0000;
      done_source <= 3'h0;
      dones <= 16'h0000;
    end
    else
    begin
      done_irq <= 1'b0;
      if (state == itdte_pkg::S_FIN && !multi_pair_enable && count == 16'h0000 &&
          mode_word[`ITDTE_MOD_INTE])
      begin
        done_irq <= 1'b1;
        done_handler <= handler_address_field;
        done_source <= src_id;
      end
      if (state == itdte_pkg::S_FIN)
        dones <= dones + 16'h0001;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_trig_not_fwd: assert property (@(posedge pclk) disable iff (!presetn)
    ((periph_req & trig_mask) != 8'h00) |=> ((cpu_irq_req & $past(periph_req & trig_mask)) == 8'h00))
    else $error("level-7 request reached the cpu");

  a_trig_caught: assert property (@(posedge pclk) disable iff (!presetn)
    ((periph_req & trig_mask) != 8'h00) |=> (pending != 8'h00 || state != itdte_pkg::S_IDLE))
    else $error("trigger was lost");

  a_zero_no_move: assert property (@(posedge pclk) disable iff (!presetn)
    (state == itdte_pkg::S_WRD && !multi_pair_enable) |-> (count != 16'h0000))
    else $error("unit moved with zero count");

  a_count_dec: assert property (@(posedge pclk) disable iff (!presetn)
    (state == itdte_pkg::S_WRD && seq_done && !multi_pair_enable) |=> (count == $past(count) - 16'h0001))
    else $error("count not decremented");

  a_dst_step: assert property (@(posedge pclk) disable iff (!presetn)
    (state == itdte_pkg::S_WRD && seq_done && !multi_pair_enable && mode_word[`ITDTE_MOD_UPDD])
    |=> (destination_field == $past(destination_field) + (unit16 ? 16'h0002 : 16'h0001)))
    else $error("destination step wrong");

  a_burst_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    burst_busy [*2] |-> (cpu_irq_req == 8'h00))
    else $error("interrupt passed during burst");

  a_chain_write: assert property (@(posedge pclk) disable iff (!presetn)
    (state == itdte_pkg::S_CHW && seq_start) |-> (acc.write && acc.len == 3'h4 && acc.wdata == chain_address_field))
    else $error("chain write malformed");

  a_done_cause: assert property (@(posedge pclk) disable iff (!presetn)
    done_irq |-> ($past(state) == itdte_pkg::S_FIN && count == 16'h0000 && mode_word[`ITDTE_MOD_INTE]))
    else $error("completion without zero count");

  a_sum_trunc: assert property (@(posedge pclk) disable iff (!presetn)
    (state == itdte_pkg::S_WRD && seq_start && !unit16) |-> (acc.wdata[31:8] == 24'h00_0000 && acc.len == 3'h1))
    else $error("8-bit unit wider than a byte");

  a_pair_range: assert property (@(posedge pclk) disable iff (!presetn)
    (state == itdte_pkg::S_PAIR) |-> (pairs_left != 3'h0 && pairs_left <= pair_quantity))
    else $error("pair count out of range");

endmodule

// ===== logic/itdte_defines.svh
// constants for the interrupt-triggered transfer engine: register offsets,
// index layout, mode word fields, reset values.
// assumes the includer is a module compiled with the itdte package.
//
// How it works
// - source field: address or immediate operand
// - operand address field only for addition
// - destination field gives write address
// - chain address present only when chaining
// - handler address present only when enabled
// - fixed field order, 8 to 18 bytes
// - multi mode: up to seven pairs
// - level-7 peripheral request triggers engine
// - vector contents give index start address
// - select=1: level-7 requests not forwarded
// - trigger ignores CPU enable and level
// - 8/16-bit units, 64-Kbyte addresses
// - 16-bit access at top spills over
// - source and destination independently incrementing
// - increment one or two per unit
// - incrementing address wraps to zero
// - immediate uses low byte for 8-bit
// - addition: source plus operand to destination
// - memory addition increments operand address too
// - burst select; zero count moves nothing
// - single: one unit per request
// - burst: loop to zero, interrupts ignored
// - at zero: chain to vector, completion
// - pair quantity one to seven
`ifndef ITDTE_DEFINES_SVH
`define ITDTE_DEFINES_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define ITDTE_OFS_CTRL 12'h000
`define ITDTE_OFS_VBASE 12'h004
`define ITDTE_OFS_STATUS 12'h008
`define ITDTE_OFS_DONES 12'h00C
`define ITDTE_CTRL_FSEL 0
`define ITDTE_CTRL_RST 1'b0
`define ITDTE_VBASE_RST 24'h00_0000

// ----------------------------------------
// mode word fields
// ----------------------------------------
`define ITDTE_MOD_UNIT16 0
`define ITDTE_MOD_SRCMEM 1
`define ITDTE_MOD_UPDS 2
`define ITDTE_MOD_UPDD 3
`define ITDTE_MOD_OPER 4
`define ITDTE_MOD_BURST_SELECT 5
`define ITDTE_MOD_INTE 6
`define ITDTE_MOD_CHAIN 7
`define ITDTE_MOD_CNT_LO 8
`define ITDTE_MOD_CNT_HI 10
`define ITDTE_MOD_MULTI_PAIR_ENABLE 11

// ----------------------------------------
// index layout and sizes
// ----------------------------------------
`define ITDTE_IDX_COUNT 24'h00_0002
`define ITDTE_IDX_SRC 24'h00_0004
`define ITDTE_NSRC 8
`define ITDTE_LVL_TRIG 3'h7
`define ITDTE_ADDR_TOP 8'h00

`endif

// ===== logic/itdte_pkg.sv
// types for the interrupt-triggered transfer engine.
// assumes nothing outside itself.
package itdte_pkg;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_VEC = 4'b0001,
    S_HDR = 4'b0010,
    S_SRC = 4'b0011,
    S_OPA = 4'b0100,
    S_DST = 4'b0101,
    S_CHN = 4'b0110,
    S_HND = 4'b0111,
    S_PAIR = 4'b1000,
    S_RDS = 4'b1001,
    S_RDO = 4'b1010,
    S_WRD = 4'b1011,
    S_WBK = 4'b1100,
    S_CHW = 4'b1101,
    S_FIN = 4'b1110
  } itdte_state_t;

  // byte-wide memory bus request
  typedef struct packed {
    logic req;
    logic we;
    logic [23:0] addr;
    logic [7:0] wdata;
  } itdte_mem_t;

  // a multi-byte access issued by the sequencer's user
  typedef struct packed {
    logic write;
    logic [23:0] addr;
    logic [2:0] len;
    logic [31:0] wdata;
  } itdte_acc_t;

endpackage

// ===== logic/itdte_mem_seq.sv
// byte sequencer: turns a 1..4 byte access into byte transfers, little endian.
// assumes a memory that answers each byte request with a one-cycle mem_ack.
`timescale 1ns/1ps
module itdte_mem_seq
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire itdte_pkg::itdte_acc_t acc,
  output itdte_pkg::itdte_mem_t mem,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata,
  output logic done,
  output logic [31:0] rdata
);

  logic busy;
  logic write;
  logic [23:0] addr;
  logic [2:0] left;
  logic [1:0] lane;
  logic [31:0] wbuf;

  // full 24-bit byte address: a 16-bit unit at 0xFFFF reaches 0x10000
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy <= 1'b0;
      write <= 1'b0;
      addr <= 24'h00_0000;
      left <= 3'h0;
      lane <= 2'h0;
      wbuf <= 32'h0000_0000;
    end
    else if (start)
    begin
      busy <= 1'b1;
      write <= acc.write;
      addr <= acc.addr;
      left <= acc.len;
      lane <= 2'h0;
      wbuf <= acc.wdata;
    end
    else if (busy && mem_ack)
    begin
      addr <= addr + 24'h00_0001;
      left <= left - 3'h1;
      lane <= lane + 2'h1;
      wbuf <= {8'h00, wbuf[31:8]};
      if (left == 3'h1)
        busy <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata <= 32'h0000_0000;
    else if (start)
      rdata <= 32'h0000_0000;
    else if (busy && mem_ack && !write)
      rdata[lane*8 +: 8] <= mem_rdata;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      done <= 1'b0;
    else
      done <= busy && mem_ack && (left == 3'h1);
  end

  always_comb
  begin
    mem.req = busy;
    mem.we = write;
    mem.addr = addr;
    mem.wdata = wbuf[7:0];
  end

endmodule

// ===== testbench/itdte_ram_model.sv
// byte-wide ram behind the engine's memory port, prompt or slow.
// assumes the bench loads and inspects bytes[] directly.
`timescale 1ns/1ps
module itdte_ram_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire itdte_pkg::itdte_mem_t mem,
  output logic mem_ack,
  output logic [7:0] mem_rdata
);
  // 17 bits so a 16-bit unit at the top spills into 0x10000
  logic [7:0] bytes [0:131071];
  logic [1:0] wait_cnt;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_ack <= 1'b0;
      wait_cnt <= 2'h0;
      mem_rdata <= 8'h00;
    end
    else if (mem.req && !mem_ack && wait_cnt == (slow ? 2'h2 : 2'h0))
    begin
      mem_ack <= 1'b1;
      mem_rdata <= bytes[mem.addr[16:0]];
      wait_cnt <= 2'h0;
    end
    else
    begin
      // read data never holds outside an ack
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_cnt <= (mem.req && !mem_ack) ? wait_cnt + 2'h1 : 2'h0;
    end
  end
  // plain always: the bench also loads bytes[] directly
  always @(posedge pclk)
  begin
    if (mem.req && mem_ack && mem.we)
      bytes[mem.addr[16:0]] <= mem.wdata;
  end
endmodule

// ===== testbench/interrupt_triggered_transfer_engine_tb.sv
// self-checking bench: apb setup, index tables in ram, level-7 triggers.
// assumes itdte_ram_model as the memory and a 25 MHz pclk.
`timescale 1ns/1ps
module interrupt_triggered_transfer_engine_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q, dh;
  logic pready, pslverr, done_irq, mem_ack, err;
  logic [7:0] periph_req = 8'h00, cpu_irq_req, mem_rdata, cq;
  logic [23:0] lvl = 24'h00_7FC7;
  logic [2:0] ds;
  itdte_pkg::itdte_mem_t mem;
  int n_mismatch = 0, comparisons = 0, n_done = 0;
  always #20 pclk = ~pclk;
  itdte_engine dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periph_req(periph_req), .request_priority_level(lvl), .cpu_irq_req(cpu_irq_req), .mem(mem),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .done_irq(done_irq), .done_handler(dh), .done_source(ds));
  itdte_ram_model ram (.pclk(pclk), .presetn(presetn), .slow(slow), .mem(mem), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  always @(posedge pclk)
  begin
    if (done_irq === 1'b1)
      n_done++;
  end
  task complete_run();
    if (n_mismatch == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    i = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && i < 20)
    begin
      @(posedge pclk);
      i++;
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (i == 20)
    begin
      n_mismatch++;
      complete_run();
    end
  endtask
  task put(input int a, input int n, input logic [31:0] v);
    for (int i = 0; i < n; i++)
      ram.bytes[a + i] = v[8 * i +: 8];
  endtask
  function automatic logic [31:0] rd(input int a, input int n);
    rd = 32'h0000_0000;
    for (int i = 0; i < n; i++)
      rd[8 * i +: 8] = ram.bytes[a + i];
  endfunction
  // pulse the sources in m, then poll status until the engine is idle
  task trig(input logic [7:0] m);
    int i;
    periph_req <= m;
    @(posedge pclk);
    periph_req <= 8'h00;
    #1 cq = cpu_irq_req;
    repeat (2) @(posedge pclk);
    for (i = 0; i < 300; i++)
    begin
      apb(1'b0, 12'h008, 32'h0000_0000);
      if (q[15:8] === 8'h00 && q[3:0] === 4'h0)
        break;
    end
    if (i == 300)
    begin
      n_mismatch++;
      complete_run();
    end
  endtask
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    apb(1'b1, 12'h000, 32'h0000_0001);
    apb(1'b1, 12'h004, 32'h0000_0100);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk(q, 32'h0000_0100);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk({31'h0000_0000, err}, 32'h0000_0001);
    // chained single 8-bit copy with completion, two requests
    put(32'h0100, 4, 32'h0000_0200);
    put(32'h0200, 4, 32'h0002_00CE);
    put(32'h0204, 4, 32'h0400_0300);
    put(32'h0208, 4, 32'h0000_0500);
    put(32'h020C, 4, 32'h1234_5678);
    put(32'h0300, 2, 32'h0000_2211);
    trig(8'h03);
    chk({24'h00_0000, cq}, 32'h0000_0002);
    chk(rd(32'h0400, 1), 32'h0000_0011);
    chk(n_done, 32'h0000_0000);
    trig(8'h01);
    chk(rd(32'h0401, 1), 32'h0000_0022);
    chk(rd(32'h0100, 4), 32'h0000_0500);
    chk(n_done, 32'h0000_0001);
    chk(dh, 32'h1234_5678);
    chk({29'h0000_0000, ds}, 32'h0000_0000);
    // burst 16-bit fill at the top of the space, slow memory
    slow <= 1'b1;
    put(32'h0108, 4, 32'h0000_0220);
    put(32'h0220, 4, 32'h0002_0029);
    put(32'h0224, 4, 32'hFFFF_ABCD);
    trig(8'h04);
    chk(rd(32'hFFFF, 2), 32'h0000_ABCD);
    chk(rd(32'h0001, 2), 32'h0000_ABCD);
    slow <= 1'b0;
    // 8-bit memory plus memory, carry dropped
    put(32'h010C, 4, 32'h0000_0240);
    put(32'h0240, 4, 32'h0001_0032);
    put(32'h0244, 4, 32'h0311_0310);
    put(32'h0248, 2, 32'h0000_0410);
    put(32'h0310, 2, 32'h0000_20F0);
    trig(8'h08);
    chk(rd(32'h0410, 1), 32'h0000_0010);
    // zero count moves nothing
    put(32'h0110, 4, 32'h0000_0260);
    put(32'h0260, 4, 32'h0000_000A);
    put(32'h0264, 4, 32'h0420_0310);
    put(32'h0420, 1, 32'h0000_005A);
    trig(8'h10);
    chk(rd(32'h0420, 1), 32'h0000_005A);
    // two-pair 8-bit multi transfer from the chained index
    put(32'h0500, 4, 32'h0000_0A02);
    put(32'h0504, 4, 32'h0430_0300);
    put(32'h0508, 4, 32'h0431_0301);
    trig(8'h01);
    chk(rd(32'h0430, 2), 32'h0000_2211);
    chk(n_done, 32'h0000_0001);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk(q, 32'h0000_0006);
    complete_run();
  end
endmodule
